// *** pm_interrupt_signalling_control_top.v ***
// Power-management channel host interrupt control with AHB-Lite registers
`timescale 1ns/100ps
`include "pm_interrupt_signalling_control_defines.vh"

module pm_interrupt_signalling_control_top (
  input wire clk,
  input wire srst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire hw_smi_event,
  input wire hw_sci_event,
  input wire hw_irq_event,
  input wire buf_op_smi,
  input wire buf_op_sci,
  input wire buf_op_irq,
  input wire data_out_port_with_smi,
  input wire data_in_port_with_sci,
  output reg smi_out,
  output reg sci_out,
  output reg irq_out
);

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  reg [7:0] sigctl;
  reg [7:0] enables;
  reg [7:0] modectl;
  reg wr_pend;
  reg [9:0] wr_addr;
  wire take;

  assign take = hsel & hready & htrans[1];

  always @(posedge clk) begin
    if (srst) begin
      wr_pend <= 1'b0;
      wr_addr <= 10'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= take & hwrite;
      if (take) begin
        wr_addr <= haddr[9:0];
      end
    end
  end

  // ----------------------------------------
  // Source selection and gating
  // ----------------------------------------
  wire smi_cond;
  wire sci_cond;
  wire irq_cond;
  wire smi_line;
  wire sci_raw;
  wire irq_raw;
  wire enh;

  assign enh = modectl[`PM_INTERRUPT_SIGNALLING_CONTROL_ENH_MODE];

  // Hardware sources: events, buffer ops in enhanced mode, data port strobes on SMI and SCI only
  assign smi_cond = enables[`PM_INTERRUPT_SIGNALLING_CONTROL_MOD_SMI_EN] & (enables[`PM_INTERRUPT_SIGNALLING_CONTROL_HW_SMI_EN] ?
    (hw_smi_event | (enh & buf_op_smi) | data_out_port_with_smi)
    : sigctl[`PM_INTERRUPT_SIGNALLING_CONTROL_SOFT_SMI]);
  assign sci_cond = enables[`PM_INTERRUPT_SIGNALLING_CONTROL_MOD_SCI_EN] & (enables[`PM_INTERRUPT_SIGNALLING_CONTROL_HW_SCI_EN] ?
    (hw_sci_event | (enh & buf_op_sci) | data_in_port_with_sci)
    : sigctl[`PM_INTERRUPT_SIGNALLING_CONTROL_SOFT_SCI]);
  assign irq_cond = enables[`PM_INTERRUPT_SIGNALLING_CONTROL_MOD_IRQ_EN] & (enables[`PM_INTERRUPT_SIGNALLING_CONTROL_HW_IRQ_EN] ?
    (hw_irq_event | (enh & buf_op_irq))
    : sigctl[`PM_INTERRUPT_SIGNALLING_CONTROL_SOFT_IRQ]);

  pm_interrupt_signalling_control_pulse #(.CW(5)) u_smi (
    .clk(clk),
    .srst(srst),
    .mode(sigctl[`PM_INTERRUPT_SIGNALLING_CONTROL_MODE_HI:`PM_INTERRUPT_SIGNALLING_CONTROL_MODE_LO]),
    .cond(smi_cond),
    .line(smi_line)
  );

  // Only SMI has a mode field; SCI and IRQ follow their conditions as levels
  assign sci_raw = sci_cond;
  assign irq_raw = irq_cond;

  always @(posedge clk) begin
    if (srst) begin
      smi_out <= 1'b1;
      sci_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      smi_out <= smi_line ^ sigctl[`PM_INTERRUPT_SIGNALLING_CONTROL_SMI_INVERT];
      sci_out <= sci_raw;
      irq_out <= irq_raw;
    end
  end

  // ----------------------------------------
  // Register writes and reads
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      sigctl <= `PM_INTERRUPT_SIGNALLING_CONTROL_SIGCTL_RST;
      enables <= `PM_INTERRUPT_SIGNALLING_CONTROL_ENABLES_RST;
      modectl <= `PM_INTERRUPT_SIGNALLING_CONTROL_MODECTL_RST;
    end else if (wr_pend) begin
      case (wr_addr)
        `PM_INTERRUPT_SIGNALLING_CONTROL_ADDR_SIGCTL: sigctl <= {1'b0, hwdata[6:0]};
        `PM_INTERRUPT_SIGNALLING_CONTROL_ADDR_ENABLES: enables <= {2'b00, hwdata[5:0]};
        `PM_INTERRUPT_SIGNALLING_CONTROL_ADDR_MODE: modectl <= {hwdata[7], 7'h00};
        default: sigctl <= sigctl;
      endcase
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      case (haddr[9:0])
        // Soft bits read back the live line state
        `PM_INTERRUPT_SIGNALLING_CONTROL_ADDR_SIGCTL: hrdata <= {24'h000000, 1'b0, sigctl[6:3],
          sci_out, smi_out, irq_out};
        `PM_INTERRUPT_SIGNALLING_CONTROL_ADDR_ENABLES: hrdata <= {24'h000000, enables};
        `PM_INTERRUPT_SIGNALLING_CONTROL_ADDR_MODE: hrdata <= {24'h000000, modectl};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// *** pm_interrupt_signalling_control_defines.vh ***
// Constants for the power-management channel interrupt control block
`ifndef PM_INTERRUPT_SIGNALLING_CONTROL_DEFINES_VH
`define PM_INTERRUPT_SIGNALLING_CONTROL_DEFINES_VH

// ----------------------------------------
// Register byte addresses (index times four)
// ----------------------------------------
`define PM_INTERRUPT_SIGNALLING_CONTROL_IDX_SIGCTL 8'h07
`define PM_INTERRUPT_SIGNALLING_CONTROL_IDX_ENABLES 8'h08
`define PM_INTERRUPT_SIGNALLING_CONTROL_IDX_MODE 8'h06
`define PM_INTERRUPT_SIGNALLING_CONTROL_ADDR_SIGCTL 10'h01c
`define PM_INTERRUPT_SIGNALLING_CONTROL_ADDR_ENABLES 10'h020
`define PM_INTERRUPT_SIGNALLING_CONTROL_ADDR_MODE 10'h018

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PM_INTERRUPT_SIGNALLING_CONTROL_SMI_INVERT 6
`define PM_INTERRUPT_SIGNALLING_CONTROL_MODE_HI 5
`define PM_INTERRUPT_SIGNALLING_CONTROL_MODE_LO 3
`define PM_INTERRUPT_SIGNALLING_CONTROL_SOFT_SCI 2
`define PM_INTERRUPT_SIGNALLING_CONTROL_SOFT_SMI 1
`define PM_INTERRUPT_SIGNALLING_CONTROL_SOFT_IRQ 0
`define PM_INTERRUPT_SIGNALLING_CONTROL_HW_SMI_EN 5
`define PM_INTERRUPT_SIGNALLING_CONTROL_HW_SCI_EN 4
`define PM_INTERRUPT_SIGNALLING_CONTROL_HW_IRQ_EN 3
`define PM_INTERRUPT_SIGNALLING_CONTROL_MOD_SMI_EN 2
`define PM_INTERRUPT_SIGNALLING_CONTROL_MOD_SCI_EN 1
`define PM_INTERRUPT_SIGNALLING_CONTROL_MOD_IRQ_EN 0
`define PM_INTERRUPT_SIGNALLING_CONTROL_ENH_MODE 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PM_INTERRUPT_SIGNALLING_CONTROL_SIGCTL_RST 8'h41
`define PM_INTERRUPT_SIGNALLING_CONTROL_ENABLES_RST 8'h00
`define PM_INTERRUPT_SIGNALLING_CONTROL_MODECTL_RST 8'h00

// ----------------------------------------
// Signalling modes
// ----------------------------------------
`define PM_INTERRUPT_SIGNALLING_CONTROL_MODE_LEVEL 3'h0
`define PM_INTERRUPT_SIGNALLING_CONTROL_MODE_P1 3'h1
`define PM_INTERRUPT_SIGNALLING_CONTROL_MODE_P2 3'h2
`define PM_INTERRUPT_SIGNALLING_CONTROL_MODE_P4 3'h3
`define PM_INTERRUPT_SIGNALLING_CONTROL_MODE_P8 3'h4
`define PM_INTERRUPT_SIGNALLING_CONTROL_MODE_P16 3'h5

`endif

// *** pm_interrupt_signalling_control_pulse.v ***
// Level or pulse shaper for one interrupt line
`timescale 1ns/100ps
`include "pm_interrupt_signalling_control_defines.vh"

module pm_interrupt_signalling_control_pulse #(
  parameter CW = 5
) (
  input wire clk,
  input wire srst,
  input wire [2:0] mode,
  input wire cond,
  output reg line
);

  reg cond_q;
  reg [CW-1:0] count;
  reg [CW-1:0] width;
  wire rise;

  assign rise = cond & ~cond_q;

  always @* begin
    case (mode)
      `PM_INTERRUPT_SIGNALLING_CONTROL_MODE_P1: width = 5'h01;
      `PM_INTERRUPT_SIGNALLING_CONTROL_MODE_P2: width = 5'h02;
      `PM_INTERRUPT_SIGNALLING_CONTROL_MODE_P4: width = 5'h04;
      `PM_INTERRUPT_SIGNALLING_CONTROL_MODE_P8: width = 5'h08;
      `PM_INTERRUPT_SIGNALLING_CONTROL_MODE_P16: width = 5'h10;
      default: width = 5'h00;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      cond_q <= 1'b0;
      count <= 5'h00;
      line <= 1'b0;
    end else begin
      cond_q <= cond;
      if (mode == `PM_INTERRUPT_SIGNALLING_CONTROL_MODE_LEVEL) begin
        line <= cond;
        count <= 5'h00;
      end else if (count != 5'h00) begin
        // Condition edges during a pulse are dropped, not merged
        count <= count - 5'h01;
        line <= (count != 5'h01);
      end else if (rise && width != 5'h00) begin
        count <= width;
        line <= 1'b1;
      end else begin
        line <= 1'b0;
      end
    end
  end

endmodule

// *** pm_interrupt_signalling_control_sva.sv ***
// Checker for the interrupt control block
`timescale 1ns/100ps
`include "pm_interrupt_signalling_control_defines.vh"
module pm_interrupt_signalling_control_sva (
  input wire clk,
  input wire srst,
  input wire hsel,
  input wire hready,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hw_sci_event,
  input wire hw_irq_event,
  input wire smi_out,
  input wire sci_out,
  input wire irq_out
);
  reg wp;
  reg [9:0] wa;
  reg [7:0] sg;
  reg [7:0] en;
  reg [1:0] q;
  wire st = q == 2'h3;
  // Shadow registers; st waits out the two-edge output latency
  always @(posedge clk) begin
    wp <= !srst && hsel && hready && htrans[1] && hwrite;
    wa <= haddr[9:0];
    q <= (srst || wp) ? 2'h0 : (st ? q : q + 2'h1);
    if (srst) begin
      sg <= `PM_INTERRUPT_SIGNALLING_CONTROL_SIGCTL_RST;
      en <= `PM_INTERRUPT_SIGNALLING_CONTROL_ENABLES_RST;
    end else if (wp && wa == `PM_INTERRUPT_SIGNALLING_CONTROL_ADDR_SIGCTL) sg <= hwdata[7:0];
    else if (wp && wa == `PM_INTERRUPT_SIGNALLING_CONTROL_ADDR_ENABLES) en <= hwdata[7:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_SCI_GATE: assert property (st && !en[1] |-> !sci_out) else $error("sci gate");
  AST_IRQ_GATE: assert property (st && !en[0] |-> !irq_out) else $error("irq gate");
  AST_SMI_IDLE: assert property (st && !en[2] |-> smi_out == sg[6]) else $error("smi idle");
  AST_SOFT_SCI: assert property (st && en[1] && !en[4] |-> sci_out == sg[2])
    else $error("soft sci");
  AST_SOFT_SMI: assert property (st && en[2] && !en[5] && sg[5:3] == 3'h0
    |-> smi_out == (sg[1] ^ sg[6])) else $error("soft smi");
  AST_HW_SCI: assert property (st && en[1] && en[4] && hw_sci_event |-> ##[1:3] sci_out)
    else $error("hw sci");
  AST_HW_IRQ: assert property (st && en[0] && en[3] && hw_irq_event |-> ##[1:3] irq_out)
    else $error("hw irq");
  AST_PULSE1: assert property (st && en[2] && sg[6:3] == 4'h1 && $rose(smi_out) |=> !smi_out)
    else $error("pulse one");
endmodule
bind pm_interrupt_signalling_control_top pm_interrupt_signalling_control_sva u_sva (.clk(clk), .srst(srst), .hsel(hsel), .hready(hready),
  .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hw_sci_event(hw_sci_event),
  .hw_irq_event(hw_irq_event), .smi_out(smi_out), .sci_out(sci_out), .irq_out(irq_out));

// *** pm_interrupt_signalling_control_host.sv ***
// Host chipset model counting SCI assertions
`timescale 1ns/100ps
module pm_interrupt_signalling_control_host (
  input wire logic clk,
  input wire logic sci_line,
  output int n_sci
);
  logic sci_d;
  initial n_sci = 0;
  always @(posedge clk) begin
    sci_d <= sci_line;
    if (sci_line && !sci_d) n_sci <= n_sci + 1;
  end
endmodule

// *** tb_top.sv ***
// Self-checking bench for the interrupt control block
`timescale 1ns/100ps
`include "pm_interrupt_signalling_control_defines.vh"
module tb_top;
  localparam [9:0] AS = `PM_INTERRUPT_SIGNALLING_CONTROL_ADDR_SIGCTL;
  localparam [9:0] AE = `PM_INTERRUPT_SIGNALLING_CONTROL_ADDR_ENABLES;
  logic clk = 0, srst = 1, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r, rnd = 32'hd790;
  logic [1:0] htrans = 0;
  logic hrdy, hresp, smi, sci, irq;
  logic [7:0] ev = 0;
  int n_mismatch = 0, n_tests = 0, n_sci, k, n, s0;
  always #5 clk = ~clk;
  pm_interrupt_signalling_control_top dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
    .hreadyout(hrdy), .hresp(hresp), .hw_smi_event(ev[0]), .hw_sci_event(ev[1]),
    .hw_irq_event(ev[2]), .buf_op_smi(ev[3]), .buf_op_sci(ev[4]), .buf_op_irq(ev[5]),
    .data_out_port_with_smi(ev[6]), .data_in_port_with_sci(ev[7]), .smi_out(smi),
    .sci_out(sci), .irq_out(irq));
  pm_interrupt_signalling_control_host host (.clk(clk), .sci_line(sci), .n_sci(n_sci));
  function automatic [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string nm, input [31:0] got, input [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic hwt;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (hrdy === 1'b1) break;
    end
    if (k == 20) n_mismatch++;
    if (k == 20) wrap_up();
  endtask
  task automatic xfer(input [9:0] a, input w, input [7:0] d);
    hsel <= 1;
    haddr <= {22'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hwt();
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    hwt();
    r = hrdata;
    repeat (4) @(posedge clk);
  endtask
  // Pulse a source for one cycle and count high SMI cycles
  task automatic pcnt(input [7:0] src);
    ev <= src;
    @(posedge clk);
    ev <= 0;
    n = 0;
    repeat (40) begin
      @(posedge clk);
      n += (smi === 1'b1);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 0;
    chk("out_rst", {smi, sci, irq}, 3'h4);
    xfer(AS, 0, 0);
    chk("sigctl_rst", r, 32'h42);
    xfer(AE, 0, 0);
    chk("en_rst", r, 0);
    xfer(10'h03c, 0, 0);
    chk("unmapped", r, 0);
    xfer(AE, 1, 8'h07);
    xfer(AS, 1, 8'h07);
    chk("soft", {smi, sci, irq}, 3'h7);
    xfer(AS, 1, 8'h40);
    chk("invert", {smi, sci, irq}, 3'h4);
    xfer(AE, 1, 8'h3f);
    xfer(AS, 1, 8'h00);
    for (int i = 0; i < 30; i++) begin
      rnd = lfsr(rnd);
      ev <= {5'h0, rnd[2:0]};
      repeat (4) @(posedge clk);
      chk("hw_level", {irq, sci, smi}, rnd[2:0]);
    end
    ev <= 0;
    for (int m = 1; m < 6; m++) begin
      xfer(AS, 1, {2'h0, m[2:0], 3'h0});
      pcnt(8'h01);
      chk("width", n, 1 << (m - 1));
    end
    pcnt(8'h40);
    chk("dout_smi", n, 16);
    s0 = n_sci;
    pcnt(8'h80);
    chk("din_sci", n_sci, s0 + 1);
    xfer(`PM_INTERRUPT_SIGNALLING_CONTROL_ADDR_MODE, 1, 8'h80);
    ev <= 8'h20;
    repeat (4) @(posedge clk);
    chk("buf_irq", irq, 1);
    ev <= 0;
    xfer(`PM_INTERRUPT_SIGNALLING_CONTROL_ADDR_MODE, 0, 0);
    chk("mode_rd", r, 32'h80);
    chk("hresp", hresp, 0);
    // Mid-run reset must restore every default
    srst <= 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    chk("out_rst2", {smi, sci, irq}, 3'h4);
    xfer(AE, 1, 8'h01);
    chk("soft_irq_rst", irq, 1);
    xfer(`PM_INTERRUPT_SIGNALLING_CONTROL_ADDR_MODE, 0, 0);
    chk("mode_rst", r, 0);
    wrap_up();
  end
endmodule
